// ---- uart9_pkg.sv ----
package uart9_pkg;
	localparam logic [11:0] DATA_INDEX = 12'h0d6;
	localparam logic [11:0] CTRL_INDEX = 12'h0d7;
	localparam logic [31:0] DATA_ADDR = {18'h0, DATA_INDEX, 2'b00};
	localparam logic [31:0] CTRL_ADDR = {18'h0, CTRL_INDEX, 2'b00};

	localparam int CR_RX_READY = 7;
	localparam int CR_TX_EMPTY = 6;
	localparam int CR_RX_IEN = 5;
	localparam int CR_TX_IEN = 4;
	localparam int CR_BAUD_HI = 3;
	localparam int CR_BAUD_LO = 1;
	localparam int CR_NINTH = 0;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;

	localparam int STATES_PER_BIT = 8;
	localparam int DATA_BITS = 9;
	localparam logic [2:0] LAST_STATE = 3'h7;
	localparam logic [2:0] SAMPLE_A = 3'h3;
	localparam logic [2:0] SAMPLE_B = 3'h4;
	localparam logic [2:0] SAMPLE_C = 3'h5;
	localparam logic [3:0] LAST_BIT = 4'h8;

	localparam logic [12:0] DIV_0 = 13'h1a00;
	localparam logic [12:0] DIV_1 = 13'h0d00;
	localparam logic [12:0] DIV_2 = 13'h0680;
	localparam logic [12:0] DIV_3 = 13'h0340;
	localparam logic [12:0] DIV_4 = 13'h01a0;
	localparam logic [12:0] DIV_5 = 13'h0100;
	localparam logic [12:0] DIV_6 = 13'h00d0;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_START = 2'b01,
		TX_DATA = 2'b10,
		TX_STOP = 2'b11
	} tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} rx_state_t;
endpackage

// ---- half_duplex_nine_bit_uart.sv ----
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - Characters are start, nine data bits, stop; never send and receive together.
// - Starting a transmission aborts any reception in progress.
// - Serial output pin carries the inverse of the transmit bit stream.
// - Without output select, serial output pin follows the port register value.
// - Baud divider gives eight time states per bit.
// - Each received bit is a two-of-three vote of three samples.
// - Baud select picks divisor 6656 down to 208; code 111 reserved.
// - Data write loads and starts transmit, clears empty flag; read returns buffer.
// - Transmit asserts select, low start bit, eight bits lsb first, then ninth.
// - After ninth bit a high stop bit, then select drops.
// - Transmission end sets empty flag; interrupt if transmit enable set.
// - Writing 0 clears empty flag, writing 1 sets it as software interrupt.
// - Ninth bit holds across transmissions; reception overwrites it.
// - When not sending, watch for falling edge, then skip start bit.
// - After nine bits wait one stop bit, then move into receive buffer.
// - Moving data into the buffer sets ready flag; interrupt if enabled.
// - Each interrupt has its own enable; flags tell the source.
// - The transceiver clock keeps running in the processor wait mode; here the divider stops whenever ce is low.
// - Control register: ready, empty, rx enable, tx enable, baud[3:1], ninth bit.
// - Writing 0 clears ready flag; writing 1 sets it as software interrupt.
// - Baud select changes act immediately, even mid character.
module half_duplex_nine_bit_uart (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic rx_in,
	input wire logic port_out_value,
	output logic serial_out_pin,
	output logic tx_output_select,
	output logic tx_irq,
	output logic rx_irq
);
	logic wr_pend_r;
	logic rd_pend_r;
	logic [31:0] addr_r;
	logic acc;
	logic data_wr;
	logic ctrl_wr;
	logic [7:0] wbyte;

	logic rx_ready_flag;
	logic tx_empty_flag;
	logic rx_irq_enable;
	logic tx_irq_enable;
	logic [2:0] baud_select;
	logic ninth_data_bit;
	logic [7:0] rx_buffer_r;

	logic [9:0] tick_cnt_r;
	logic [9:0] tick_lim;
	logic tick;
	logic div_restart;

	uart9_pkg::tx_state_t tx_state_r;
	logic [2:0] tx_phase_r;
	logic [3:0] tx_bit_r;
	logic [8:0] tx_shift_r;
	logic tx_line;
	logic tx_done;

	uart9_pkg::rx_state_t rx_state_r;
	logic [2:0] rx_phase_r;
	logic [3:0] rx_bit_r;
	logic [8:0] rx_shift_r;
	logic [2:0] rx_votes_r;
	logic rx_prev_r;
	logic rx_edge;
	logic rx_done;
	logic vote;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign acc = hsel & htrans[1] & hready;
	assign wbyte = hwdata[7:0];
	assign data_wr = wr_pend_r & (addr_r == uart9_pkg::DATA_ADDR);
	assign ctrl_wr = wr_pend_r & (addr_r == uart9_pkg::CTRL_ADDR);

	// Bus address phase capture
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r <= 32'h0;
		end else if (ce) begin
			wr_pend_r <= acc & hwrite;
			rd_pend_r <= acc & ~hwrite;
			if (acc) begin
				addr_r <= {haddr[31:2], 2'b00};
			end
		end
	end

	// Read data; unmapped reads as zero
	always_comb begin
		hrdata = 32'h0;
		if (rd_pend_r) begin
			if (addr_r == uart9_pkg::DATA_ADDR) begin
				hrdata = {24'h0, rx_buffer_r};
			end else if (addr_r == uart9_pkg::CTRL_ADDR) begin
				hrdata = {24'h0, rx_ready_flag, tx_empty_flag, rx_irq_enable,
					tx_irq_enable, baud_select, ninth_data_bit};
			end
		end
	end

	// Enables and baud select
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_irq_enable <= uart9_pkg::CTRL_RESET[uart9_pkg::CR_RX_IEN];
			tx_irq_enable <= uart9_pkg::CTRL_RESET[uart9_pkg::CR_TX_IEN];
			baud_select <= uart9_pkg::CTRL_RESET[uart9_pkg::CR_BAUD_HI:uart9_pkg::CR_BAUD_LO];
		end else if (ce && ctrl_wr) begin
			rx_irq_enable <= wbyte[uart9_pkg::CR_RX_IEN];
			tx_irq_enable <= wbyte[uart9_pkg::CR_TX_IEN];
			baud_select <= wbyte[uart9_pkg::CR_BAUD_HI:uart9_pkg::CR_BAUD_LO];
		end
	end

	// Receive ready flag; hardware set wins
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_ready_flag <= uart9_pkg::CTRL_RESET[uart9_pkg::CR_RX_READY];
		end else if (ce) begin
			if (rx_done) begin
				rx_ready_flag <= 1'b1;
			end else if (ctrl_wr) begin
				rx_ready_flag <= wbyte[uart9_pkg::CR_RX_READY];
			end
		end
	end

	// Transmit empty flag; hardware set wins
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_empty_flag <= uart9_pkg::CTRL_RESET[uart9_pkg::CR_TX_EMPTY];
		end else if (ce) begin
			if (tx_done) begin
				tx_empty_flag <= 1'b1;
			end else if (data_wr) begin
				tx_empty_flag <= 1'b0;
			end else if (ctrl_wr) begin
				tx_empty_flag <= wbyte[uart9_pkg::CR_TX_EMPTY];
			end
		end
	end

	// Ninth bit: programmed value kept, received bit overwrites
	always_ff @(posedge clk) begin
		if (rst) begin
			ninth_data_bit <= uart9_pkg::CTRL_RESET[uart9_pkg::CR_NINTH];
		end else if (ce) begin
			if (rx_done) begin
				ninth_data_bit <= rx_shift_r[8];
			end else if (ctrl_wr) begin
				ninth_data_bit <= wbyte[uart9_pkg::CR_NINTH];
			end
		end
	end

	// Receive buffer
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_buffer_r <= uart9_pkg::DATA_RESET;
		end else if (ce && rx_done) begin
			rx_buffer_r <= rx_shift_r[7:0];
		end
	end

	// Interrupt requests, each gated by its own enable
	assign tx_irq = tx_empty_flag & tx_irq_enable;
	assign rx_irq = rx_ready_flag & rx_irq_enable;

	// Divisor per baud code, in clocks per time state
	always_comb begin
		case (baud_select)
			3'h0: tick_lim = uart9_pkg::DIV_0[12:3];
			3'h1: tick_lim = uart9_pkg::DIV_1[12:3];
			3'h2: tick_lim = uart9_pkg::DIV_2[12:3];
			3'h3: tick_lim = uart9_pkg::DIV_3[12:3];
			3'h4: tick_lim = uart9_pkg::DIV_4[12:3];
			3'h5: tick_lim = uart9_pkg::DIV_5[12:3];
			3'h6: tick_lim = uart9_pkg::DIV_6[12:3];
			default: tick_lim = uart9_pkg::DIV_6[12:3];
		endcase
	end

	assign tick = (tick_cnt_r >= tick_lim - 10'h1);
	assign div_restart = data_wr | rx_edge;

	// Time-state divider, gated by ce like all other logic; it only advances while ce is high
	always_ff @(posedge clk) begin
		if (rst) begin
			tick_cnt_r <= 10'h0;
		end else if (ce) begin
			if (div_restart || tick) begin
				tick_cnt_r <= 10'h0;
			end else begin
				tick_cnt_r <= tick_cnt_r + 10'h1;
			end
		end
	end

	assign tx_done = (tx_state_r == uart9_pkg::TX_STOP) & tick
		& (tx_phase_r == uart9_pkg::LAST_STATE);

	// Transmitter
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_state_r <= uart9_pkg::TX_IDLE;
			tx_phase_r <= 3'h0;
			tx_bit_r <= 4'h0;
			tx_shift_r <= 9'h1ff;
		end else if (ce) begin
			if (data_wr) begin
				tx_state_r <= uart9_pkg::TX_START;
				tx_phase_r <= 3'h0;
				tx_bit_r <= 4'h0;
				tx_shift_r <= {ninth_data_bit, wbyte};
			end else if (tick) begin
				tx_phase_r <= tx_phase_r + 3'h1;
				if (tx_phase_r == uart9_pkg::LAST_STATE) begin
					case (tx_state_r)
						uart9_pkg::TX_START: begin
							tx_state_r <= uart9_pkg::TX_DATA;
						end
						uart9_pkg::TX_DATA: begin
							tx_shift_r <= {1'b1, tx_shift_r[8:1]};
							tx_bit_r <= tx_bit_r + 4'h1;
							if (tx_bit_r == uart9_pkg::LAST_BIT) begin
								tx_state_r <= uart9_pkg::TX_STOP;
							end
						end
						uart9_pkg::TX_STOP: begin
							tx_state_r <= uart9_pkg::TX_IDLE;
						end
						default: begin
							tx_state_r <= uart9_pkg::TX_IDLE;
						end
					endcase
				end
			end
		end
	end

	always_comb begin
		case (tx_state_r)
			uart9_pkg::TX_START: tx_line = 1'b0;
			uart9_pkg::TX_DATA: tx_line = tx_shift_r[0];
			default: tx_line = 1'b1;
		endcase
	end

	assign tx_output_select = (tx_state_r != uart9_pkg::TX_IDLE);
	assign serial_out_pin = tx_output_select ? ~tx_line : port_out_value;

	// Receiver: edge detect only while not sending
	assign rx_edge = rx_prev_r & ~rx_in & (rx_state_r == uart9_pkg::RX_IDLE)
		& ~tx_output_select & ~data_wr;
	assign vote = (rx_votes_r[0] & rx_votes_r[1]) | (rx_votes_r[0] & rx_votes_r[2])
		| (rx_votes_r[1] & rx_votes_r[2]);
	assign rx_done = (rx_state_r == uart9_pkg::RX_STOP) & tick
		& (rx_phase_r == uart9_pkg::LAST_STATE) & ~data_wr;

	always_ff @(posedge clk) begin
		if (rst) begin
			rx_prev_r <= 1'b1;
		end else if (ce) begin
			rx_prev_r <= rx_in;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rx_votes_r <= 3'h0;
		end else if (ce && tick) begin
			case (rx_phase_r)
				uart9_pkg::SAMPLE_A: rx_votes_r[0] <= rx_in;
				uart9_pkg::SAMPLE_B: rx_votes_r[1] <= rx_in;
				uart9_pkg::SAMPLE_C: rx_votes_r[2] <= rx_in;
				default: rx_votes_r <= rx_votes_r;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rx_state_r <= uart9_pkg::RX_IDLE;
			rx_phase_r <= 3'h0;
			rx_bit_r <= 4'h0;
			rx_shift_r <= 9'h0;
		end else if (ce) begin
			if (data_wr || tx_output_select) begin
				rx_state_r <= uart9_pkg::RX_IDLE;
				rx_phase_r <= 3'h0;
			end else if (rx_edge) begin
				rx_state_r <= uart9_pkg::RX_START;
				rx_phase_r <= 3'h0;
				rx_bit_r <= 4'h0;
			end else if (tick && rx_state_r != uart9_pkg::RX_IDLE) begin
				rx_phase_r <= rx_phase_r + 3'h1;
				if (rx_phase_r == uart9_pkg::LAST_STATE) begin
					case (rx_state_r)
						uart9_pkg::RX_START: begin
							rx_state_r <= uart9_pkg::RX_DATA;
						end
						uart9_pkg::RX_DATA: begin
							rx_shift_r <= {vote, rx_shift_r[8:1]};
							rx_bit_r <= rx_bit_r + 4'h1;
							if (rx_bit_r == uart9_pkg::LAST_BIT) begin
								rx_state_r <= uart9_pkg::RX_STOP;
							end
						end
						uart9_pkg::RX_STOP: begin
							rx_state_r <= uart9_pkg::RX_IDLE;
						end
						default: begin
							rx_state_r <= uart9_pkg::RX_IDLE;
						end
					endcase
				end
			end
		end
	end
endmodule

// ---- remote_station.sv ----
`timescale 1ns/1ps
module remote_station #(parameter int BIT_CLKS = 208) (
	input logic clk,
	input logic tx_line,
	output logic rx_line
);
	logic [8:0] got_q[$];
	logic [8:0] sh;
	initial rx_line = 1'b1;
	// Start, nine bits lsb first, stop; parity left to software
	task automatic send_char(input logic [8:0] d, input logic glitch);
		logic [10:0] fr;
		fr = {1'b1, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rx_line <= fr[i];
			repeat (BIT_CLKS * 9 / 16) @(posedge clk);
			// Spoil only the middle one of the three samples
			rx_line <= glitch ? ~fr[i] : fr[i];
			repeat (BIT_CLKS / 8) @(posedge clk);
			rx_line <= fr[i];
			repeat (BIT_CLKS - BIT_CLKS * 9 / 16 - BIT_CLKS / 8) @(posedge clk);
		end
	endtask
	always begin
		@(negedge tx_line);
		repeat (BIT_CLKS / 2) @(posedge clk);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT_CLKS) @(posedge clk);
			sh[i] = tx_line;
		end
		got_q.push_back(sh);
	end
endmodule

// ---- half_duplex_nine_bit_uart_assertions.sv ----
`timescale 1ns/1ps
module uart9_checker (
	input logic clk,
	input logic rst,
	input logic ce,
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic hready,
	input logic hreadyout,
	input logic hresp,
	input logic [31:0] hrdata,
	input logic port_out_value,
	input logic serial_out_pin,
	input logic tx_output_select,
	input logic tx_irq,
	input logic rx_irq
);
	// Eleven bits at the fastest divisor
	localparam logic [15:0] MIN_CHAR = 16'h08f0;
	logic wr_ph;
	logic rd_ph;
	logic [15:0] sel_cnt;
	wire take = hsel & htrans[1] & hready & ce;
	always_ff @(posedge clk) begin
		wr_ph <= !rst & take & hwrite & (haddr == uart9_pkg::DATA_ADDR);
		rd_ph <= !rst & take & !hwrite;
	end
	always_ff @(posedge clk) begin
		if (rst || !tx_output_select) begin
			sel_cnt <= 16'h0;
		end else begin
			sel_cnt <= sel_cnt + 16'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_port_when_idle: assert property (!tx_output_select |-> serial_out_pin == port_out_value)
		else $error("pin ignores port");
	a_start_bit_high: assert property ($rose(tx_output_select) |-> serial_out_pin)
		else $error("bad start level");
	a_stop_bit_low: assert property ($fell(tx_output_select) |-> !$past(serial_out_pin))
		else $error("bad stop level");
	a_frame_length: assert property ($fell(tx_output_select) |-> sel_cnt >= MIN_CHAR)
		else $error("short frame");
	a_bit_held: assert property ($changed(serial_out_pin) && tx_output_select
		&& $past(tx_output_select) |=> $stable(serial_out_pin)[*8])
		else $error("bit too short");
	a_write_starts_tx: assert property (wr_ph |=> tx_output_select)
		else $error("no start");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus response");
	a_rdata_quiet: assert property (!rd_ph |-> hrdata == 32'h0)
		else $error("stray read data");
	a_reset_quiet: assert property ($fell(rst) |-> !tx_output_select && !tx_irq && !rx_irq)
		else $error("reset state");
	c_tx: cover property ($rose(tx_output_select));
	c_rx: cover property ($rose(rx_irq));
	c_rd: cover property (rd_ph);
endmodule
bind half_duplex_nine_bit_uart uart9_checker u_uart9_checker (.clk(clk), .rst(rst), .ce(ce),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .port_out_value(port_out_value),
	.serial_out_pin(serial_out_pin), .tx_output_select(tx_output_select), .tx_irq(tx_irq),
	.rx_irq(rx_irq));

// ---- half_duplex_nine_bit_uart_test.sv ----
`timescale 1ns/1ps
module half_duplex_nine_bit_uart_test;
	localparam logic [31:0] CR = uart9_pkg::CTRL_ADDR;
	localparam logic [31:0] DR = uart9_pkg::DATA_ADDR;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic port_out_value = 1'b1;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd_s, rd;
	logic hreadyout, hresp, serial_out_pin, tx_output_select, tx_irq, rx_irq, rx_line;
	logic [8:0] ch;
	logic [7:0] ctrl_m;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	int n;
	int div_m[7] = '{6656, 3328, 1664, 832, 416, 256, 208};
	// External stage restores polarity; a constant high gives the idle stop state
	wire far_line = tx_output_select ? ~serial_out_pin : 1'b1;
	always #10 clk = ~clk;
	half_duplex_nine_bit_uart u_half_duplex_nine_bit_uart (.clk(clk), .rst(rst), .ce(ce),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .rx_in(rx_line), .port_out_value(port_out_value),
		.serial_out_pin(serial_out_pin), .tx_output_select(tx_output_select),
		.tx_irq(tx_irq), .rx_irq(rx_irq));
	remote_station u_remote_station (.clk(clk), .tx_line(far_line), .rx_line(rx_line));
	task automatic give_verdict();
		if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		rd_s <= hrdata;
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			miscompares++;
			give_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		@(negedge clk);
		rd = rd_s;
		@(posedge clk);
	endtask
	task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	initial begin
		void'($urandom(32'hb1c5eb22));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdc(CR, 32'h0);
		rdc(DR, 32'h0);
		rdc(32'h0, 32'h0);
		for (int c = 0; c < 7; c++) begin
			bus(1'b1, CR, 32'(c * 2));
			bus(1'b1, DR, 32'h1);
			n = 1;
			@(negedge clk);
			while (serial_out_pin === 1'b1) begin
				n++;
				@(negedge clk);
			end
			chk(32'(n), 32'(div_m[c]));
			@(posedge clk);
			rst <= 1'b1;
			repeat (2) @(posedge clk);
			rst <= 1'b0;
		end
		repeat (2400) begin
			@(posedge clk);
			port_out_value <= 1'($urandom);
		end
		@(posedge clk);
		port_out_value <= 1'b1;
		ce <= 1'b0;
		bus(1'b1, CR, 32'hff);
		ce <= 1'b1;
		rdc(CR, 32'h0);
		u_remote_station.got_q.delete();
		ctrl_m = 8'h3d;
		bus(1'b1, CR, 32'(ctrl_m));
		rdc(CR, 32'(ctrl_m));
		repeat (2) begin
			ch = {1'b1, 8'($urandom)};
			bus(1'b1, DR, 32'(ch[7:0]));
			@(negedge tx_output_select);
			@(posedge clk);
			chk(32'(u_remote_station.got_q.pop_front()), 32'(ch));
			chk(32'(tx_irq), 32'h1);
		end
		rdc(CR, 32'(ctrl_m | 8'h40));
		bus(1'b1, CR, 32'(ctrl_m));
		chk(32'(tx_irq), 32'h0);
		bus(1'b1, CR, 32'(ctrl_m | 8'hc0));
		chk(32'({tx_irq, rx_irq}), 32'h3);
		bus(1'b1, CR, 32'hcd);
		chk(32'({tx_irq, rx_irq}), 32'h0);
		bus(1'b1, CR, 32'(ctrl_m));
		for (int k = 0; k < 2; k++) begin
			ch = {k[0], 8'($urandom)};
			u_remote_station.send_char(ch, k == 0);
			n = 0;
			while (rx_irq !== 1'b1 && n < 400) begin
				n++;
				@(posedge clk);
			end
			chk(32'(rx_irq), 32'h1);
			rdc(DR, 32'(ch[7:0]));
			rdc(CR, 32'({1'b1, ctrl_m[6:1], ch[8]}));
			bus(1'b1, CR, 32'(ctrl_m));
		end
		fork
			u_remote_station.send_char(9'h0a5, 1'b0);
			begin
				repeat (624) @(posedge clk);
				bus(1'b1, DR, 32'h5a);
			end
		join
		@(negedge tx_output_select);
		@(posedge clk);
		chk(32'(u_remote_station.got_q.pop_front()), 32'h15a);
		rdc(CR, 32'(ctrl_m | 8'h40));
		give_verdict();
	end
endmodule
